// file: rtl/usl_map.svh
// Purpose: Offsets, field positions, key and read values and timing counts of the sleep/loopback block
// Assumes: 50 MHz system clock
// Notes:   Definitions only
`ifndef USL_MAP_SVH
`define USL_MAP_SVH
`define USL_A_HOLD      3'h0
`define USL_A_IER       3'h1
`define USL_A_ISR       3'h2
`define USL_A_LCR       3'h3
`define USL_A_MCR       3'h4
`define USL_A_LSR       3'h5
`define USL_A_MSR       3'h6
`define USL_A_SPR       3'h7
`define USL_ISR_NONE    0
`define USL_IER_SLEEP   4
`define USL_EFR_ENH     4
`define USL_MCR_LOOP    4
`define USL_LCR_DLAB    7
`define USL_LCR_ENH     8'hBF
`define USL_RD_ZERO     8'h00
`define USL_CLK_MHZ     50
`define USL_CP_IDLE_S   30
`define USL_CP_WAKE_US  45
`define USL_CP_IDLE_CYC (`USL_CP_IDLE_S * `USL_CLK_MHZ * 1000000)
`define USL_CP_WAKE_CYC (`USL_CP_WAKE_US * `USL_CLK_MHZ)
`endif

// file: rtl/usl_pkg.sv
// Purpose: Types of the sleep/loopback block
// Assumes: Widths match usl_map.svh
// Notes:   Module state other than the ast_wait check counter is one packed struct
package usl_pkg;
	typedef enum logic {USL_UART_AWAKE, USL_UART_ASLEEP} usl_uart_st_t;
	typedef enum logic [1:0] {USL_CP_ON, USL_CP_OFF, USL_CP_WAKING} usl_cp_st_t;

	typedef struct packed {
		logic       cs;
		logic       rd;
		logic       wr;
		logic [2:0] addr;
		logic [7:0] data;
		logic       rxd;
		logic       cts_n;
		logic       charge_pump_autosleep_pin;
	} usl_pins_t;

	typedef struct packed {
		logic [7:0] dll;
		logic [7:0] divisor_high;
		logic [7:0] interrupt_enable;
		logic [7:0] enhanced_function;
		logic [7:0] line_control;
		logic [7:0] modem_control;
		logic [7:0] scratchpad;
		logic [7:0] xon1;
		logic [7:0] xon2;
		logic [7:0] xoff1;
		logic [7:0] xoff2;
	} usl_cfg_t;

	typedef struct packed {
		usl_pins_t    s1;
		usl_pins_t    s2;
		logic         cs_d;
		logic         rd_d;
		logic         wr_d;
		logic         rxd_d;
		usl_cfg_t     cfg;
		usl_uart_st_t uart_st;
		usl_cp_st_t   cp_st;
		logic [30:0]  idle_cnt;
		logic [11:0]  wake_cnt;
		logic [7:0]   data_out;
		logic         data_oe;
		logic [7:0]   wr_data;
		logic         hold_wr;
		logic         fifo_ctrl_wr;
		logic         rhr_rd;
		logic         txd;
		logic         rts_n;
		logic         rx_core;
		logic         cts_n_core;
		logic         osc_en;
		logic         cp_en;
		logic         cp_ready;
		logic         drv_oe;
	} usl_state_t;
endpackage

// file: rtl/usl_top.sv
// Purpose: Power management, loopback and register decode of a UART with RS-232 transceiver
// Assumes: SYS_CLK runs free; the crystal oscillator is gated by CRYSTAL_OUT_PIN_EN
// Notes:   Host bus pins are asynchronous and pass two flip-flops first
// Overview of operation
// - Sleep needs no interrupt, divisor, enable, idle
// - Sleeping stops the crystal oscillator output
// - Receive rising edge or transmit write wakes
// - Resleep automatically; never sleep while pending
// - Sleep behaviour lasts until enable cleared
// - Autosleep pin low keeps pump on
// - Pump off after thirty seconds quiet
// - Pump off tri-states drivers, registers stay
// - Pump wakes on activity, ready after 45us
// - Full sleep when asleep and pin high
// - Leave full sleep on pin low, oscillator
// - Modem control bit four enables loopback
// - Transmit output loops into receive input
// - Transmit and RTS pins high, inputs ignored
// - Three address lines decoded under chip select
// - Address zero: holding or divisor low
// - Address one: interrupt enable or divisor high
// - Zero divisor shows revision and identity
// - Address two: status, FIFO control, enhanced
// - Line control always; upper four normal set
// - Enhanced bank writes four flow characters
// - Upper enable bits need enhanced enable
`timescale 1ns/1ns
`include "usl_map.svh"
module usl_top #(
	parameter int unsigned IDLE_CYCLES = `USL_CP_IDLE_CYC,
	parameter logic [7:0]  REV_CODE    = 8'h01,
	parameter logic [7:0]  ID_CODE     = 8'h02
) (
	input  wire logic             SYS_CLK,
	input  wire logic             RST_N,
	input  wire logic             CS_N,
	input  wire logic             RD_N,
	input  wire logic             WR_N,
	input  wire logic [2:0]       ADDR,
	input  wire logic [7:0]       DATA_IN,
	output logic      [7:0]       DATA_OUT,
	output logic                  DATA_OE,
	input  wire logic             RXD_PIN,
	input  wire logic             CTS_N_PIN,
	input  wire logic             CHARGE_PUMP_AUTOSLEEP_PIN,
	output logic                  TXD_PIN,
	output logic                  RTS_N_PIN,
	output logic                  CRYSTAL_OUT_PIN_EN,
	output logic                  CHARGE_PUMP_EN,
	output logic                  CHARGE_PUMP_READY,
	output logic                  DRIVER_OE,
	input  wire logic             TX_FROM_CORE,
	input  wire logic             RTS_N_FROM_CORE,
	input  wire logic             TX_BUSY,
	input  wire logic [7:0]       ISR_IN,
	input  wire logic [7:0]       LSR_IN,
	input  wire logic [7:0]       MSR_IN,
	input  wire logic [7:0]       RHR_IN,
	output logic                  RX_TO_CORE,
	output logic                  CTS_N_TO_CORE,
	output logic                  HOLD_WR,
	output logic                  FIFO_CTRL_WR,
	output logic                  RHR_RD,
	output logic      [7:0]       WR_DATA,
	output usl_pkg::usl_cfg_t     CFG
);
	localparam logic [30:0] IDLE_LAST = 31'(IDLE_CYCLES - 1);
	localparam logic [11:0] WAKE_LAST = 12'(`USL_CP_WAKE_CYC - 1);
	localparam int          WAKE_CYC  = `USL_CP_WAKE_CYC;

	generate
		if (IDLE_CYCLES < 2 || IDLE_CYCLES > 32'h7FFF_FFFF)
		begin : g_bad_idle
			$error("IDLE_CYCLES out of range");
		end
		if (WAKE_CYC < 2 || WAKE_CYC > 4096)
		begin : g_bad_wake
			$error("Pump wake count does not fit its counter");
		end
	endgenerate

	usl_pkg::usl_state_t cur;
	usl_pkg::usl_state_t nxt;
	logic                wr_go;
	logic                rd_end;
	logic                enh;
	logic                dlab;
	logic                div_zero;
	logic [2:0]          addr;
	logic [7:0]          d;
	logic [7:0]          rdat;
	logic                thr_go;
	logic                rx_edge;
	logic                tx_act;
	logic                wake;
	logic                sleep_ok;
	logic                idle_done;
	logic                loop;

	always_comb
	begin
		nxt          = cur;
		nxt.s1.cs    = !CS_N;
		nxt.s1.rd    = !RD_N;
		nxt.s1.wr    = !WR_N;
		nxt.s1.addr  = ADDR;
		nxt.s1.data  = DATA_IN;
		nxt.s1.rxd   = RXD_PIN;
		nxt.s1.cts_n = CTS_N_PIN;
		nxt.s1.charge_pump_autosleep_pin   = CHARGE_PUMP_AUTOSLEEP_PIN;
		nxt.s2       = cur.s1;
		nxt.cs_d     = cur.s2.cs;
		nxt.rd_d     = cur.s2.rd;
		nxt.wr_d     = cur.s2.wr;
		nxt.rxd_d    = cur.s2.rxd;

		// Strobe ends qualify the access, so address and data have settled
		wr_go    = cur.wr_d && !cur.s2.wr && cur.cs_d;
		rd_end   = cur.rd_d && !cur.s2.rd && cur.cs_d;
		addr     = cur.s2.addr;
		d        = cur.s2.data;
		enh      = cur.cfg.line_control == `USL_LCR_ENH;
		dlab     = cur.cfg.line_control[`USL_LCR_DLAB];
		div_zero = {cur.cfg.divisor_high, cur.cfg.dll} == 16'h0000;
		thr_go   = wr_go && addr == `USL_A_HOLD && !dlab;

		nxt.hold_wr      = 1'b0;
		nxt.fifo_ctrl_wr = 1'b0;
		nxt.rhr_rd       = rd_end && addr == `USL_A_HOLD && !dlab;
		if (wr_go)
		begin
			nxt.wr_data = d;
			case (addr)
				`USL_A_HOLD:
				begin
					if (dlab)
						nxt.cfg.dll = d;
					else
						nxt.hold_wr = 1'b1;
				end
				`USL_A_IER:
				begin
					if (dlab)
						nxt.cfg.divisor_high = d;
					else if (cur.cfg.enhanced_function[`USL_EFR_ENH])
						nxt.cfg.interrupt_enable = d;
					else
						nxt.cfg.interrupt_enable = {cur.cfg.interrupt_enable[7:4], d[3:0]};
				end
				`USL_A_ISR:
				begin
					if (enh)
						nxt.cfg.enhanced_function = d;
					else
						nxt.fifo_ctrl_wr = 1'b1;
				end
				`USL_A_LCR: nxt.cfg.line_control = d;
				`USL_A_MCR:
				begin
					if (enh)
						nxt.cfg.xon1 = d;
					else
						nxt.cfg.modem_control = d;
				end
				`USL_A_LSR:
				begin
					// Line status is read only; outside the enhanced bank the write is dropped
					if (enh)
						nxt.cfg.xon2 = d;
				end
				`USL_A_MSR:
				begin
					if (enh)
						nxt.cfg.xoff1 = d;
				end
				`USL_A_SPR:
				begin
					if (enh)
						nxt.cfg.xoff2 = d;
					else
						nxt.cfg.scratchpad = d;
				end
				default: nxt.wr_data = d;
			endcase
		end

		// Flow characters are write only, so the enhanced bank reads zero above address 3
		case (addr)
			`USL_A_HOLD: rdat = dlab ? (div_zero ? REV_CODE : cur.cfg.dll) : RHR_IN;
			`USL_A_IER:  rdat = dlab ? (div_zero ? ID_CODE : cur.cfg.divisor_high) : cur.cfg.interrupt_enable;
			`USL_A_ISR:  rdat = enh ? cur.cfg.enhanced_function : ISR_IN;
			`USL_A_LCR:  rdat = cur.cfg.line_control;
			`USL_A_MCR:  rdat = enh ? `USL_RD_ZERO : cur.cfg.modem_control;
			`USL_A_LSR:  rdat = enh ? `USL_RD_ZERO : LSR_IN;
			`USL_A_MSR:  rdat = enh ? `USL_RD_ZERO : MSR_IN;
			`USL_A_SPR:  rdat = enh ? `USL_RD_ZERO : cur.cfg.scratchpad;
			default:     rdat = `USL_RD_ZERO;
		endcase
		nxt.data_oe  = cur.s2.cs && cur.s2.rd;
		nxt.data_out = rdat;

		// Wake sources are seen on the free clock, so a stopped oscillator loses none
		rx_edge  = !cur.rxd_d && cur.s2.rxd;
		tx_act   = thr_go || TX_BUSY;
		wake     = rx_edge || thr_go;
		sleep_ok = ISR_IN[`USL_ISR_NONE] && !div_zero && cur.cfg.interrupt_enable[`USL_IER_SLEEP]
			&& !cur.s2.rxd && !TX_BUSY && !wake;

		case (cur.uart_st)
			usl_pkg::USL_UART_AWAKE:
			begin
				if (sleep_ok)
					nxt.uart_st = usl_pkg::USL_UART_ASLEEP;
			end
			usl_pkg::USL_UART_ASLEEP:
			begin
				if (wake || !cur.cfg.interrupt_enable[`USL_IER_SLEEP])
					nxt.uart_st = usl_pkg::USL_UART_AWAKE;
			end
			default: nxt.uart_st = usl_pkg::USL_UART_AWAKE;
		endcase

		if (tx_act || rx_edge || cur.s2.rxd)
			nxt.idle_cnt = 31'h0000_0000;
		else if (cur.idle_cnt != IDLE_LAST)
			nxt.idle_cnt = cur.idle_cnt + 31'h0000_0001;
		idle_done = cur.idle_cnt == IDLE_LAST;

		case (cur.cp_st)
			usl_pkg::USL_CP_ON:
			begin
				if (!cur.s2.charge_pump_autosleep_pin)
					nxt.cp_st = usl_pkg::USL_CP_ON;
				else if (cur.uart_st == usl_pkg::USL_UART_ASLEEP && !wake)
					nxt.cp_st = usl_pkg::USL_CP_OFF;
				else if (idle_done && !tx_act && !rx_edge)
					nxt.cp_st = usl_pkg::USL_CP_OFF;
			end
			usl_pkg::USL_CP_OFF:
			begin
				if (!cur.s2.charge_pump_autosleep_pin || wake || nxt.uart_st == usl_pkg::USL_UART_AWAKE
					&& cur.uart_st == usl_pkg::USL_UART_ASLEEP)
				begin
					nxt.cp_st    = usl_pkg::USL_CP_WAKING;
					nxt.wake_cnt = 12'h000;
				end
			end
			usl_pkg::USL_CP_WAKING:
			begin
				// Settling time is a fixed count; the pump itself gives no ready flag
				if (cur.wake_cnt == WAKE_LAST)
					nxt.cp_st = usl_pkg::USL_CP_ON;
				else
					nxt.wake_cnt = cur.wake_cnt + 12'h001;
			end
			default: nxt.cp_st = usl_pkg::USL_CP_ON;
		endcase
		nxt.osc_en   = nxt.uart_st == usl_pkg::USL_UART_AWAKE;
		nxt.cp_en    = nxt.cp_st != usl_pkg::USL_CP_OFF;
		nxt.cp_ready = nxt.cp_st == usl_pkg::USL_CP_ON;
		nxt.drv_oe   = nxt.cp_st == usl_pkg::USL_CP_ON;

		// External inputs are dropped during loopback; the partner must keep the line quiet
		loop           = cur.cfg.modem_control[`USL_MCR_LOOP];
		nxt.rx_core    = loop ? TX_FROM_CORE : cur.s2.rxd;
		nxt.cts_n_core = loop ? RTS_N_FROM_CORE : cur.s2.cts_n;
		nxt.txd        = loop ? 1'b1 : TX_FROM_CORE;
		nxt.rts_n      = loop ? 1'b1 : RTS_N_FROM_CORE;
	end

	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			cur <= '0;
		else
			cur <= nxt;
	end

	assign DATA_OUT           = cur.data_out;
	assign DATA_OE            = cur.data_oe;
	assign TXD_PIN            = cur.txd;
	assign RTS_N_PIN          = cur.rts_n;
	assign CRYSTAL_OUT_PIN_EN = cur.osc_en;
	assign CHARGE_PUMP_EN     = cur.cp_en;
	assign CHARGE_PUMP_READY  = cur.cp_ready;
	assign DRIVER_OE          = cur.drv_oe;
	assign RX_TO_CORE         = cur.rx_core;
	assign CTS_N_TO_CORE      = cur.cts_n_core;
	assign HOLD_WR            = cur.hold_wr;
	assign FIFO_CTRL_WR       = cur.fifo_ctrl_wr;
	assign RHR_RD             = cur.rhr_rd;
	assign WR_DATA            = cur.wr_data;
	assign CFG                = cur.cfg;

	// Helper for the pump settling check
	logic [12:0] ast_wait;
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			ast_wait <= 13'h0000;
		else if (cur.cp_st == usl_pkg::USL_CP_OFF)
			ast_wait <= 13'h0000;
		else if (!cur.cp_ready)
			ast_wait <= ast_wait + 13'h0001;
	end

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	AST_LOOP_TX_HIGH: assert property (loop |=> TXD_PIN && RTS_N_PIN)
		else $error("Pins not held high in loopback");
	AST_LOOP_RETURN: assert property (loop |=> RX_TO_CORE == $past(TX_FROM_CORE))
		else $error("Loopback path broken");
	AST_NO_SLEEP_PEND: assert property (!CRYSTAL_OUT_PIN_EN && $past(CRYSTAL_OUT_PIN_EN) |->
		$past(ISR_IN[`USL_ISR_NONE]) && $past(CFG.interrupt_enable[`USL_IER_SLEEP]) && $past(CFG.divisor_high != 8'h00 || CFG.dll != 8'h00))
		else $error("Sleep entered against its conditions");
	AST_WAKE_ON_WRITE: assert property (HOLD_WR |-> CRYSTAL_OUT_PIN_EN)
		else $error("Transmit write did not wake oscillator");
	AST_RX_WAKE: assert property (rx_edge && cur.uart_st == usl_pkg::USL_UART_ASLEEP |=> ##0 CRYSTAL_OUT_PIN_EN)
		else $error("Receive edge did not wake oscillator");
	AST_UPPER_IER: assert property (!cur.cfg.enhanced_function[`USL_EFR_ENH] |=> CFG.interrupt_enable[7:4] == $past(CFG.interrupt_enable[7:4]))
		else $error("Upper enable bits changed while locked");
	AST_ACP_LOW_PUMP: assert property (!cur.s2.charge_pump_autosleep_pin |=> CHARGE_PUMP_EN)
		else $error("Pump off with autosleep pin low");
	AST_DRIVER_TRI: assert property (!CHARGE_PUMP_EN |-> !DRIVER_OE ##1 (CHARGE_PUMP_EN || !DRIVER_OE))
		else $error("Drivers enabled without pump");
	AST_PUMP_SETTLE: assert property ($rose(CHARGE_PUMP_READY) && $past(cur.cp_st) == usl_pkg::USL_CP_WAKING |-> ast_wait == 13'(WAKE_CYC))
		else $error("Pump settling time wrong");
	AST_FULL_SLEEP: assert property (cur.uart_st == usl_pkg::USL_UART_ASLEEP && cur.s2.charge_pump_autosleep_pin && !wake && cur.cp_st == usl_pkg::USL_CP_ON |=> !CHARGE_PUMP_EN)
		else $error("Full sleep not entered");

	COV_SLEEP: cover property (CRYSTAL_OUT_PIN_EN ##1 !CRYSTAL_OUT_PIN_EN);
	COV_PUMP_CYCLE: cover property (!CHARGE_PUMP_EN ##1 CHARGE_PUMP_EN);
	COV_LOOP_READ: cover property (loop && RHR_RD);
	COV_ID_READ: cover property (DATA_OE && dlab && div_zero);
endmodule

// file: testbench/test_uart_sleep_loopback_regmap.sv
// Purpose: Self-checking bench of the sleep, loopback and decode block
// Assumes: Idle timer shortened to 50 cycles
// Notes:   Host model drives the bus; the bench drives the core side
`timescale 1ns/1ns
module test_uart_sleep_loopback_regmap;
	localparam logic [7:0] REV = 8'h3A; // Arbitrary value
	localparam logic [7:0] ID  = 8'h5C; // Arbitrary value
	logic              sys_clk, rst_n, cs_n, rd_n, wr_n, oe;
	logic [2:0]        addr;
	logic [7:0]        din, dout, wr_data, interrupt_status;
	logic              rxd, cts_n, charge_pump_autosleep_pin, txd, rts_n, osc, cp_en, cp_rdy, drv_oe;
	logic              tx_core, rts_core, rx_core, cts_core, hold_wr, fcr_wr, rhr_rd;
	usl_pkg::usl_cfg_t cfg;
	int                mismatches, n_tests, n;
	int                n_hold, n_fcr, n_pop;

	usl_top #(.IDLE_CYCLES(50), .REV_CODE(REV), .ID_CODE(ID)) usl_top_i (
		.SYS_CLK(sys_clk), .RST_N(rst_n), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
		.ADDR(addr), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe), .RXD_PIN(rxd),
		.CTS_N_PIN(cts_n), .CHARGE_PUMP_AUTOSLEEP_PIN(charge_pump_autosleep_pin), .TXD_PIN(txd),
		.RTS_N_PIN(rts_n), .CRYSTAL_OUT_PIN_EN(osc), .CHARGE_PUMP_EN(cp_en),
		.CHARGE_PUMP_READY(cp_rdy), .DRIVER_OE(drv_oe), .TX_FROM_CORE(tx_core),
		.RTS_N_FROM_CORE(rts_core), .TX_BUSY(1'b0), .ISR_IN(interrupt_status), .LSR_IN(8'h60),
		.MSR_IN(8'hB0), .RHR_IN(8'hC3), .RX_TO_CORE(rx_core), .CTS_N_TO_CORE(cts_core),
		.HOLD_WR(hold_wr), .FIFO_CTRL_WR(fcr_wr), .RHR_RD(rhr_rd), .WR_DATA(wr_data),
		.CFG(cfg));
	usl_host usl_host_i (.SYS_CLK(sys_clk), .DATA_OUT(dout), .CS_N(cs_n), .RD_N(rd_n),
		.WR_N(wr_n), .ADDR(addr), .DATA_IN(din));

	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// One-cycle strobes are counted so a task can judge them after it returns
	always @(posedge sys_clk)
	begin
		if (hold_wr === 1'b1)
			n_hold++;
		if (fcr_wr === 1'b1)
			n_fcr++;
		if (rhr_rd === 1'b1)
			n_pop++;
	end

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask
	task automatic chkn(input int got, input int exp);
		n_tests++;
		if (got != exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] d;
		usl_host_i.rd(a, d);
		chk8(d, exp);
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return osc;
			1: return cp_en;
			default: return cp_rdy;
		endcase
	endfunction
	// Bounded polling so a stuck power state ends the run instead of hanging it
	task automatic wait_for(input int s, input logic v, input int lim, output int k);
		k = 0;
		while (sig(s) !== v && k < lim)
		begin
			@(posedge sys_clk);
			#1 k++;
		end
		if (k >= lim)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, sig(s), v);
			conclude();
		end
	endtask

	task automatic t_regs();
		usl_host_i.wr(3'h7, 8'hA5);
		rd_chk(3'h7, 8'hA5);
		rd_chk(3'h3, 8'h00);
		rd_chk(3'h2, interrupt_status);
		rd_chk(3'h5, 8'h60);
		rd_chk(3'h6, 8'hB0);
		rd_chk(3'h0, 8'hC3);
		chkn(n_pop, 1);
		usl_host_i.wr(3'h0, 8'h3C);
		chk8(wr_data, 8'h3C);
		chkn(n_hold, 1);
		usl_host_i.wr(3'h3, 8'h80);
		rd_chk(3'h0, REV);
		rd_chk(3'h1, ID);
		usl_host_i.wr(3'h0, 8'h05);
		rd_chk(3'h0, 8'h05);
		rd_chk(3'h1, 8'h00);
		chkn(n_pop, 1);
		usl_host_i.wr(3'h3, 8'h00);
		usl_host_i.wr(3'h2, 8'h07);
		chkn(n_fcr, 1);
		chk8(wr_data, 8'h07);
		chk1(oe, 1'b0);
	endtask
	task automatic t_enh();
		usl_host_i.wr(3'h1, 8'hF0);
		chk8(cfg.interrupt_enable, 8'h00);
		usl_host_i.wr(3'h3, 8'hBF);
		usl_host_i.wr(3'h2, 8'h10);
		rd_chk(3'h2, 8'h10);
		rd_chk(3'h3, 8'hBF);
		usl_host_i.wr(3'h4, 8'h11);
		usl_host_i.wr(3'h5, 8'h22);
		usl_host_i.wr(3'h6, 8'h33);
		usl_host_i.wr(3'h7, 8'h44);
		chk8({cfg.xon1[3:0], cfg.xon2[3:0]}, 8'h12);
		chk8({cfg.xoff1[3:0], cfg.xoff2[3:0]}, 8'h34);
		usl_host_i.wr(3'h3, 8'h00);
		usl_host_i.wr(3'h1, 8'hE0);
		chk8(cfg.interrupt_enable, 8'hE0);
	endtask
	task automatic t_sleep();
		usl_host_i.wr(3'h1, 8'h10);
		wait_for(0, 1'b0, 20, n);
		chk1(cp_en, 1'b1);
		@(posedge sys_clk);
		interrupt_status <= 8'h00;
		rxd <= 1'b1;
		wait_for(0, 1'b1, 20, n);
		@(posedge sys_clk);
		rxd <= 1'b0;
		repeat (30) @(posedge sys_clk);
		#1 chk1(osc, 1'b1);
		@(posedge sys_clk);
		interrupt_status <= 8'h01;
		wait_for(0, 1'b0, 20, n);
		fork
			usl_host_i.wr(3'h0, 8'h5A);
			wait_for(0, 1'b1, 30, n);
		join
		chk8(wr_data, 8'h5A);
		usl_host_i.wr(3'h1, 8'h00);
		repeat (20) @(posedge sys_clk);
		#1 chk1(osc, 1'b1);
	endtask
	task automatic t_pump();
		@(posedge sys_clk);
		charge_pump_autosleep_pin <= 1'b1;
		wait_for(1, 1'b0, 300, n);
		chk1(drv_oe, 1'b0);
		rd_chk(3'h7, 8'hA5);
		@(posedge sys_clk);
		rxd <= 1'b1;
		wait_for(1, 1'b1, 20, n);
		wait_for(2, 1'b1, 2300, n);
		chkn(n, 2250);
		chk1(drv_oe, 1'b1);
		@(posedge sys_clk);
		rxd <= 1'b0;
		usl_host_i.wr(3'h1, 8'h10);
		wait_for(0, 1'b0, 20, n);
		wait_for(1, 1'b0, 300, n);
		@(posedge sys_clk);
		charge_pump_autosleep_pin <= 1'b0;
		wait_for(1, 1'b1, 20, n);
		wait_for(2, 1'b1, 2300, n);
		chkn(n, 2250);
		usl_host_i.wr(3'h1, 8'h00);
	endtask
	task automatic t_loop();
		usl_host_i.wr(3'h4, 8'h10);
		chk8(cfg.modem_control, 8'h10);
		// The receive pin stays low throughout the loop test
		for (int i = 0; i < 4; i++)
		begin
			@(posedge sys_clk);
			tx_core <= i[0];
			rts_core <= i[1];
			cts_n <= ~i[1];
			@(posedge sys_clk);
			#1 chk1(rx_core, tx_core);
			chk1(cts_core, rts_core);
			chk1(txd, 1'b1);
			chk1(rts_n, 1'b1);
		end
		@(posedge sys_clk);
		tx_core <= 1'b0;
		usl_host_i.wr(3'h4, 8'h00);
		chk1(txd, 1'b0);
	endtask

	initial
	begin
		mismatches = 0;
		n_tests = 0;
		n_hold = 0;
		n_fcr = 0;
		n_pop = 0;
		rst_n = 1'b0;
		rxd = 1'b0;
		cts_n = 1'b1;
		charge_pump_autosleep_pin = 1'b0;
		tx_core = 1'b1;
		rts_core = 1'b1;
		interrupt_status = 8'h01;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		#1 chk1(osc, 1'b1);
		t_regs();
		t_enh();
		t_sleep();
		t_pump();
		t_loop();
		conclude();
	end
endmodule

// file: testbench/usl_host.sv
// Purpose: Host processor model on the parallel register bus
// Assumes: Strobes low and high for at least 3 cycles each
// Notes:   Released data lines show the inverted last value
`timescale 1ns/1ns
module usl_host (
	input  wire logic       SYS_CLK,
	input  wire logic [7:0] DATA_OUT,
	output logic            CS_N,
	output logic            RD_N,
	output logic            WR_N,
	output logic      [2:0] ADDR,
	output logic      [7:0] DATA_IN
);
	initial
	begin
		CS_N = 1'b1;
		RD_N = 1'b1;
		WR_N = 1'b1;
		ADDR = 3'h0;
		DATA_IN = 8'h00;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge SYS_CLK);
	endtask
	// Address and data stand 3 cycles around the strobe for the synchroniser
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge SYS_CLK);
		ADDR <= a;
		DATA_IN <= d;
		CS_N <= 1'b0;
		cyc(3);
		WR_N <= 1'b0;
		cyc(3);
		WR_N <= 1'b1;
		cyc(3);
		CS_N <= 1'b1;
		DATA_IN <= ~d;
		cyc(3);
		#1;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge SYS_CLK);
		ADDR <= a;
		cyc(3);
		CS_N <= 1'b0;
		RD_N <= 1'b0;
		cyc(5);
		#1 d = DATA_OUT;
		@(posedge SYS_CLK);
		RD_N <= 1'b1;
		CS_N <= 1'b1;
		cyc(5);
		#1;
	endtask
endmodule
